// ===== sacst_pkg.sv
// sacst_pkg: constants and types for the conversion sequencer and serial port.
// assumes: system clock of 125 MHz; serial clock supplied by the host.
`default_nettype none
package sacst_pkg;
   localparam int unsigned CLK_MHZ = 125;
   // times in ns as specified
   localparam int unsigned T_CONV_WARP_NS = 825;
   localparam int unsigned T_CONV_NORM_NS = 925;
   localparam int unsigned T_QUIET_WARP_NS = 400;
   localparam int unsigned T_QUIET_NORM_NS = 500;
   // longest times round down to whole cycles
   localparam int unsigned CONV_WARP_CYC = T_CONV_WARP_NS * CLK_MHZ / 1000;
   localparam int unsigned CONV_NORM_CYC = T_CONV_NORM_NS * CLK_MHZ / 1000;
   localparam int unsigned QUIET_WARP_CYC = T_QUIET_WARP_NS * CLK_MHZ / 1000;
   localparam int unsigned QUIET_NORM_CYC = T_QUIET_NORM_NS * CLK_MHZ / 1000;
   // cycles spent in the pin synchroniser and edge detector before counting
   localparam int unsigned SYNC_LAT = 3;
   localparam int unsigned RES_W = 16;
   localparam int unsigned CFG_W = 16;
   localparam int unsigned WORD_W = RES_W + CFG_W;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned BIT_W = 5;
   localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
   localparam logic SPEED_WARP = 1'b0;
   typedef enum logic [2:0] {
      SACST_IDLE = 3'b001,
      SACST_QUIET = 3'b010,
      SACST_CONV = 3'b100
   } sacst_state_t;
endpackage : sacst_pkg
`default_nettype wire

// ===== sacst_link_if.sv
// sacst_link_if: signals between the core (system clock) and the serial engine.
// assumes: tx_word changes only at end of conversion or on a device reset rise, outside host access windows.
`default_nettype none
interface sacst_link_if;
   import sacst_pkg::*;
   logic [WORD_W-1:0] tx_word;
   logic [CFG_W-1:0] cfg_word;
   logic cfg_tgl;
   logic serial_result_out;
   logic srst;
   modport core (output tx_word, output srst, input cfg_word, input cfg_tgl, input serial_result_out);
   modport link (input tx_word, input srst, output cfg_word, output cfg_tgl, output serial_result_out);
endinterface : sacst_link_if
`default_nettype wire

// ===== sacst_serial.sv
// sacst_serial: shift engine on the host serial clock.
// assumes: the serial clock runs only while chip select is low.
`default_nettype none
module sacst_serial (
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_din,
   sacst_link_if.link lnk
);
   import sacst_pkg::*;

   logic [IDX_W-1:0] out_idx_ff;
   logic [BIT_W-1:0] in_cnt_ff;
   logic [CFG_W-1:0] cfg_sr_ff;
   logic [CFG_W-1:0] cfg_word_ff;
   logic cfg_tgl_ff;

   ////////////////////////////////////////////////////////////////////////////
   // the clock stops between frames, so chip select itself clears the counters
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         out_idx_ff <= '0;
      end else if (out_idx_ff != IDX_W'(WORD_W)) begin
         out_idx_ff <= out_idx_ff + 1'b1;                 // [R11] [R12]
      end
   end

   // result msb first, then config readback, no gap; zeros after 32 bits
   assign lnk.serial_result_out = (out_idx_ff < IDX_W'(WORD_W)) ?
                    lnk.tx_word[WORD_W - 1 - 32'(out_idx_ff)] : 1'b0;  // [R19]

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         in_cnt_ff <= '0;
         cfg_sr_ff <= '0;
      end else begin
         cfg_sr_ff <= {cfg_sr_ff[CFG_W-2:0], i_din};       // [R12] [R17]
         in_cnt_ff <= (in_cnt_ff == BIT_W'(CFG_W - 1)) ? '0 : in_cnt_ff + 1'b1;
      end
   end

   // completed word held and announced by a toggle to the system clock;
   // the toggle must start known, or the core could never see it change
   always_ff @(posedge i_sclk or posedge lnk.srst) begin
      if (lnk.srst) begin
         cfg_word_ff <= CFG_RST;
         cfg_tgl_ff <= 1'b0;
      end else if (!i_cs_n && in_cnt_ff == BIT_W'(CFG_W - 1)) begin
         cfg_word_ff <= {cfg_sr_ff[CFG_W-2:0], i_din};     // [R17]
         cfg_tgl_ff <= ~cfg_tgl_ff;
      end
   end

   assign lnk.cfg_word = cfg_word_ff;
   assign lnk.cfg_tgl = cfg_tgl_ff;
endmodule : sacst_serial
`default_nettype wire

// ===== sacst_core.sv
// sacst_core: conversion sequencing and serial data access of a 16-bit SAR converter.
// assumes: the sample code is produced by converter logic on i_mclk; the host drives
// the serial clock, chip select, convert start and the control pins.
// What the block and its host must do
// R1 - host spaces convert starts by 1/1.1 us
// R2 - host keeps warp interval under 1000 us
// R3 - result ready 825/925 ns after start
// R4 - speed select 0 warp, 1 normal
// R5 - busy rises within 520 ns of start
// R6 - quiet part bounded 400/500 ns
// R7 - host finishes in-conversion read within 500 ns
// R8 - host reads only early while busy
// R9 - reads allowed during, after, or both
// R10 - result and config update only at end
// R11 - 16 falling edges result, 16 config
// R12 - drive on falling, sample on rising
// R13 - output tristated while cs, reset, powerdown high
// R14 - chip select held, tied, or independent
// R15 - host waits aperture delay before access
// R16 - result readable right after its conversion
// R17 - 16-bit config shifted in on rising edges
// R18 - reset pin rise aborts, restores config
// R19 - msb first, config follows without gap
// R20 - busy falls when result is available
`default_nettype none
module sacst_core (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_sclk,
   input wire logic i_convert_start,
   input wire logic i_cs_n,
   input wire logic i_din,
   input wire logic i_dev_reset,
   input wire logic i_power_down,
   input wire logic i_conv_speed_select,
   input wire logic [sacst_pkg::RES_W-1:0] i_sample_code,
   output logic o_busy,
   output logic o_quiet,
   output logic o_serial_result_out,
   output logic o_serial_result_oe,
   output logic [sacst_pkg::CFG_W-1:0] o_active_cfg
);
   import sacst_pkg::*;

   // end counts absorb the pin sync latency so busy tracks the pin edge
   function automatic logic [CNT_W-1:0] conv_end(input logic warp);
      conv_end = warp ? CNT_W'(CONV_WARP_CYC - SYNC_LAT) : CNT_W'(CONV_NORM_CYC - SYNC_LAT);
   endfunction : conv_end

   function automatic logic [CNT_W-1:0] quiet_end(input logic warp);
      quiet_end = warp ? CNT_W'(QUIET_WARP_CYC - SYNC_LAT) : CNT_W'(QUIET_NORM_CYC - SYNC_LAT);
   endfunction : quiet_end

   sacst_link_if lnk ();

   // serial clock is stopped while the system is in reset, so the
   // unsynchronised release of this reset cannot meet a serial edge
   assign lnk.srst = i_sys_rst;

   sacst_serial u_serial (
      .i_sclk(i_sclk),
      .i_cs_n(i_cs_n),
      .i_din(i_din),
      .lnk(lnk.link)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by the second
   logic [1:0] cnv_sync_ff;
   logic [1:0] cs_sync_ff;
   logic [1:0] rst_sync_ff;
   logic [1:0] pd_sync_ff;
   logic [1:0] spd_sync_ff;
   logic [1:0] tgl_sync_ff;
   logic cnv_prev_ff;
   logic rst_prev_ff;
   logic tgl_prev_ff;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cnv_sync_ff <= '0;
         cs_sync_ff <= 2'h3;
         rst_sync_ff <= '0;
         pd_sync_ff <= '0;
         spd_sync_ff <= 2'h3;
         tgl_sync_ff <= '0;
      end else begin
         cnv_sync_ff <= {cnv_sync_ff[0], i_convert_start};
         cs_sync_ff <= {cs_sync_ff[0], i_cs_n};
         rst_sync_ff <= {rst_sync_ff[0], i_dev_reset};
         pd_sync_ff <= {pd_sync_ff[0], i_power_down};
         spd_sync_ff <= {spd_sync_ff[0], i_conv_speed_select};
         tgl_sync_ff <= {tgl_sync_ff[0], lnk.cfg_tgl};
      end
   end

   // edge history: reset values match the idle pins, so no false edge
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cnv_prev_ff <= 1'b0;
         rst_prev_ff <= 1'b0;
         tgl_prev_ff <= 1'b0;
      end else begin
         cnv_prev_ff <= cnv_sync_ff[1];
         rst_prev_ff <= rst_sync_ff[1];
         tgl_prev_ff <= tgl_sync_ff[1];
      end
   end

   logic cnv_rise;
   logic rst_rise;
   logic cfg_arrived;
   assign cnv_rise = cnv_sync_ff[1] & ~cnv_prev_ff;
   assign rst_rise = rst_sync_ff[1] & ~rst_prev_ff;
   assign cfg_arrived = tgl_sync_ff[1] ^ tgl_prev_ff;

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   sacst_state_t state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic warp_ff;
   logic eoc;

   // a start while reset or power-down is high is ignored
   assign eoc = (state_ff != SACST_IDLE) && (cnt_ff == conv_end(warp_ff));  // [R3] [R20]

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state_ff <= SACST_IDLE;
         cnt_ff <= '0;
         warp_ff <= 1'b0;
      end else if (rst_rise || rst_sync_ff[1] || pd_sync_ff[1]) begin
         state_ff <= SACST_IDLE;                          // [R18]
         cnt_ff <= '0;
      end else begin
         case (state_ff)
            SACST_IDLE: begin
               if (cnv_rise) begin
                  state_ff <= SACST_QUIET;                // [R5]
                  cnt_ff <= '0;
                  warp_ff <= (spd_sync_ff[1] == SPEED_WARP);  // [R4]
               end
            end
            SACST_QUIET: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == quiet_end(warp_ff)) begin
                  state_ff <= SACST_CONV;                 // [R6]
               end
            end
            SACST_CONV: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (eoc) begin
                  state_ff <= SACST_IDLE;                 // [R20]
                  cnt_ff <= '0;
               end
            end
            default: begin
               state_ff <= SACST_IDLE;
               cnt_ff <= '0;
            end
         endcase
      end
   end

   assign o_busy = (state_ff != SACST_IDLE);              // [R5] [R20]
   assign o_quiet = (state_ff == SACST_QUIET);            // [R6]

   ////////////////////////////////////////////////////////////////////////////
   // config: newest written word waits here until end of conversion
   logic [CFG_W-1:0] cfg_pend_ff;
   logic [CFG_W-1:0] cfg_act_ff;
   logic eoc_load;
   logic [CFG_W-1:0] cfg_next;

   // a word arriving in the end cycle is taken at once: the set wins
   assign eoc_load = eoc && (state_ff == SACST_CONV);
   assign cfg_next = cfg_arrived ? lnk.cfg_word : cfg_pend_ff;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || rst_rise) begin
         cfg_pend_ff <= CFG_RST;                          // [R18]
      end else if (cfg_arrived) begin
         cfg_pend_ff <= lnk.cfg_word;                     // [R17]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || rst_rise) begin
         cfg_act_ff <= CFG_RST;                           // [R18]
      end else if (eoc_load) begin
         cfg_act_ff <= cfg_next;                          // [R10]
      end
   end

   assign o_active_cfg = cfg_act_ff;

   ////////////////////////////////////////////////////////////////////////////
   // output word: changes only at end of conversion or on a device reset rise, so the host never
   // sees it move inside its permitted access windows
   logic [WORD_W-1:0] tx_word_ff;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || rst_rise) begin
         tx_word_ff <= {{RES_W{1'b0}}, CFG_RST};
      end else if (eoc_load) begin
         tx_word_ff <= {i_sample_code, cfg_next};         // [R10] [R16] [R19]
      end
   end

   assign lnk.tx_word = tx_word_ff;                       // [R9]

   ////////////////////////////////////////////////////////////////////////////
   logic oe_ff;
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= ~cs_sync_ff[1] & ~rst_sync_ff[1] & ~pd_sync_ff[1];  // [R13]
      end
   end

   assign o_serial_result_oe = oe_ff;                     // [R13]
   assign o_serial_result_out = oe_ff ? lnk.serial_result_out : 1'b0;   // [R12]
endmodule : sacst_core
`default_nettype wire

// ===== sacst_core_sva.sv
// sacst_core_sva: port-level timing checks of the conversion sequencer.
// assumes: bound to sacst_core; speed select held steady through a conversion.
`default_nettype none
module sacst_chk (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_convert_start,
   input wire logic i_cs_n,
   input wire logic i_dev_reset,
   input wire logic i_power_down,
   input wire logic i_conv_speed_select,
   input wire logic o_busy,
   input wire logic o_quiet,
   input wire logic o_serial_result_out,
   input wire logic o_serial_result_oe,
   input wire logic [sacst_pkg::CFG_W-1:0] o_active_cfg
);
   import sacst_pkg::*;
   logic [7:0] busy_cnt_ff;
   logic [7:0] quiet_cnt_ff;
   always_ff @(posedge i_mclk) begin
      busy_cnt_ff <= o_busy ? busy_cnt_ff + 8'h01 : 8'h00;
   end
   always_ff @(posedge i_mclk) begin
      quiet_cnt_ff <= o_quiet ? quiet_cnt_ff + 8'h01 : 8'h00;
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_start;
      $rose(i_convert_start) ##0 (!o_busy && !i_dev_reset && !i_power_down);
   endsequence
   sequence s_end;
      $fell(o_busy) ##0 (!i_dev_reset && !i_power_down);
   endsequence
   AST_BUSY_RISE: assert property (s_start |-> ##[1:5] o_busy)
      else $error("busy late after convert start");
   // window is the sync-phase jitter around the typical figure, capped at 1000 ns normal and 824 ns warp
   AST_CONV_TIME: assert property (s_end |-> (i_conv_speed_select ?
      (busy_cnt_ff inside {[108:125]}) : (busy_cnt_ff inside {[96:103]})))
      else $error("conversion length wrong for speed");
   AST_QUIET_IN_BUSY: assert property (o_quiet |-> o_busy)
      else $error("quiet outside busy");
   AST_QUIET_FIRST: assert property ($rose(o_busy) |-> o_quiet)
      else $error("busy opened without quiet phase");
   AST_QUIET_TIME: assert property ($fell(o_quiet) && o_busy |->
      quiet_cnt_ff <= (i_conv_speed_select ? 8'h3E : 8'h32))
      else $error("quiet phase too long");
   AST_HIZ: assert property ((i_cs_n || i_dev_reset || i_power_down)[*4] |->
      !o_serial_result_oe)
      else $error("output driven while deselected");
   AST_DRIVE: assert property ((!i_cs_n && !i_dev_reset && !i_power_down)[*5] |->
      o_serial_result_oe)
      else $error("output not driven while selected");
   AST_OUT_ZERO: assert property (!o_serial_result_oe |-> !o_serial_result_out)
      else $error("data toggles while released");
   AST_CFG_EOC: assert property ($changed(o_active_cfg) && !i_dev_reset |-> $fell(o_busy))
      else $error("config changed outside end of conversion");
   AST_REFUSE: assert property ((i_dev_reset || i_power_down)[*6] |-> !o_busy)
      else $error("busy while reset or powered down");
endmodule : sacst_chk
`default_nettype wire

// ===== sacst_host.sv
// sacst_host: behavioural host framing 32 serial clocks per read.
// assumes: a frame starts on a rising i_go; serial clock idles low between frames.
`default_nettype none
module sacst_host (
   input wire logic i_go,
   input wire logic [15:0] i_cfg,
   input wire logic i_sdo,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_din,
   output logic [31:0] o_word,
   output logic o_done
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din = 1'b1;
      o_word = 32'h00000000;
      o_done = 1'b0;
   end
   // reads start only after busy falls, so no access near the sampling edge
   always @(posedge i_go) begin
      #3 o_cs_n = 1'b0;
      // output enable follows chip select through the pin synchroniser
      #30;
      for (int i = 0; i < 32; i++) begin
         o_din = i_cfg[15 - (i % 16)];
         #15 o_sclk = 1'b1;
         o_word = {o_word[30:0], i_sdo};
         #15 o_sclk = 1'b0;
      end
      #15 o_cs_n = 1'b1;
      // released line must not keep its last value
      o_din = ~o_din;
      o_done = 1'b1;
      #15 o_done = 1'b0;
   end
endmodule : sacst_host
`default_nettype wire

// ===== sacst_core_tb.sv
// sacst_core_tb: self-checking bench for conversion timing and serial readback.
// assumes: host model sacst_host and checker sacst_chk compiled first.
`default_nettype none
module sacst_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sacst_pkg::*;
   logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_convert_start = 1'b0, go = 1'b0;
   logic i_dev_reset = 1'b0, i_power_down = 1'b0, i_conv_speed_select = 1'b1;
   logic [RES_W-1:0] i_sample_code = 16'h0000;
   logic [CFG_W-1:0] cfg_pend = CFG_RST, cfg_act = CFG_RST, o_active_cfg;
   logic sclk, cs_n, din, o_busy, o_quiet, serial_result_out, oe, done;
   logic [31:0] word;
   logic [31:0] exp_q[$];
   int miscompares = 0, samples_checked = 0, cyc = 0;
   always #4 i_mclk = ~i_mclk;
   sacst_core uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(sclk),
      .i_convert_start(i_convert_start), .i_cs_n(cs_n), .i_din(din),
      .i_dev_reset(i_dev_reset), .i_power_down(i_power_down),
      .i_conv_speed_select(i_conv_speed_select), .i_sample_code(i_sample_code),
      .o_busy(o_busy), .o_quiet(o_quiet), .o_serial_result_out(serial_result_out),
      .o_serial_result_oe(oe), .o_active_cfg(o_active_cfg));
   sacst_host host (.i_go(go), .i_cfg(cfg_pend), .i_sdo(serial_result_out), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_din(din), .o_word(word), .o_done(done));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge done) check("word", exp_q.pop_front(), word);
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic convert(input logic sel);
      int n;
      n = 0;
      @(negedge i_mclk);
      i_conv_speed_select = sel;
      i_sample_code = 16'($urandom);
      i_convert_start = 1'b1;
      repeat (6) @(negedge i_mclk);
      i_convert_start = 1'b0;
      check("busy_rise", 32'h1, o_busy);
      while (o_busy === 1'b1 && n < 200) begin
         @(negedge i_mclk);
         n++;
      end
      check("conv_time", 32'h1, (n + 6) inside {[(sel ? 108 : 96) : (sel ? 125 : 104)]});
      cfg_act = cfg_pend;
      check("cfg", cfg_act, o_active_cfg);
   endtask : convert
   task automatic read_frame(input logic [31:0] exp);
      exp_q.push_back(exp);
      cfg_pend = 16'($urandom);
      @(negedge i_mclk);
      go = 1'b1;
      repeat (20) @(negedge i_mclk);
      check("oe_frame", 32'(!i_power_down), oe);
      @(posedge done);
      repeat (5) @(negedge i_mclk);
      go = 1'b0;
      check("oe_idle", 32'h0, oe);
   endtask : read_frame
   initial begin
      void'($urandom(32'h8EAEB86A));
      repeat (10) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      // spacing stays above the minimum and far below the warp ceiling
      for (int i = 0; i < 6; i++) begin
         convert(i[0]);
         read_frame({i_sample_code, cfg_act});
      end
      $display("test convert and readback done");
      @(negedge i_mclk);
      i_convert_start = 1'b1;
      repeat (20) @(negedge i_mclk);
      i_dev_reset = 1'b1;
      repeat (10) @(negedge i_mclk);
      check("abort_busy", 32'h0, o_busy);
      check("abort_cfg", CFG_RST, o_active_cfg);
      i_dev_reset = 1'b0;
      i_convert_start = 1'b0;
      $display("test device reset abort done");
      repeat (8) @(negedge i_mclk);
      i_power_down = 1'b1;
      repeat (8) @(negedge i_mclk);
      i_convert_start = 1'b1;
      repeat (10) @(negedge i_mclk);
      check("pd_busy", 32'h0, o_busy);
      check("pd_oe", 32'h0, oe);
      read_frame(32'h0);
      i_convert_start = 1'b0;
      i_power_down = 1'b0;
      $display("test power down done");
      repeat (10) @(negedge i_mclk);
      tally_and_finish();
   end
endmodule : sacst_core_tb
bind sacst_core sacst_chk chk (.i_mclk, .i_sys_rst, .i_convert_start, .i_cs_n, .i_dev_reset,
   .i_power_down, .i_conv_speed_select, .o_busy, .o_quiet, .o_serial_result_out,
   .o_serial_result_oe, .o_active_cfg);
`default_nettype wire
